// ===== ocl_output_contact_logic.v
// Output contact combination, latching, hold timing, system contact and analog scaler
`timescale 1ns/1ns
`default_nettype none
`include "ocl_map.vh"

module ocl_output_contact_logic (
   input  wire                 mclk_i,
   input  wire                 resetn_i,
   input  wire [27:0]          trig_i,
   input  wire [3:0]           ch_ack_i,
   input  wire                 global_output_ack_i,
   input  wire                 panel_clear_i,
   input  wire [3:0]           latch_restore_i,
   input  wire                 restore_valid_i,
   input  wire                 fault_i,
   input  wire signed [15:0]   ao_value_i,
   input  wire                 ao_p_neg_i,
   input  wire                 ao_q_neg_i,
   input  wire [11:0]          s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output reg                  s_axi_awready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output reg                  s_axi_wready,
   output reg  [1:0]           s_axi_bresp,
   output reg                  s_axi_bvalid,
   input  wire                 s_axi_bready,
   input  wire [11:0]          s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output reg                  s_axi_arready,
   output reg  [31:0]          s_axi_rdata,
   output reg  [1:0]           s_axi_rresp,
   output reg                  s_axi_rvalid,
   input  wire                 s_axi_rready,
   output reg  [3:0]           relay_o,
   output reg                  system_contact_o,
   output reg  [15:0]          ao_code_o
);

   // ==========================================
   // Configuration registers
   reg  [31:0]        ctrl;
   reg  [18:0]        ch_cfg [0:3];
   reg  [2:0]         ao_cfg;
   reg  signed [15:0] ao_min;
   reg  signed [15:0] ao_max;
   reg  [31:0]        hold_cyc;
   reg  [31:0]        offdly_cyc;
   reg  [2:0]         ack_pulse;
   reg  [3:0]         latched;
   reg  [3:0]         drive;
   reg  [3:0]         collective;

   // ==========================================
   // AXI write channel
   reg  [11:0] aw_addr;
   reg         aw_have;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_have;
   wire        wr_go = aw_have & w_have & ~s_axi_bvalid;
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] ctrl_w = (ctrl & ~wmask) | (w_data & wmask);
   integer i;

   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         ctrl          <= 32'h0000_0000;
         ao_cfg        <= 3'h0;
         ao_min        <= 16'h0000;
         ao_max        <= 16'h7FFF;
         hold_cyc      <= `OCL_HOLD_RST;
         offdly_cyc    <= `OCL_OFFDLY_RST;
         ack_pulse     <= 3'h0;
         for (i = 0; i < 4; i = i + 1) begin
            ch_cfg[i] <= 19'h00000;
         end
      end else begin
         ack_pulse     <= 3'h0;
         s_axi_awready <= ~aw_have & ~s_axi_awready;
         s_axi_wready  <= ~w_have & ~s_axi_wready;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            case (aw_addr)
               `OCL_REG_CTRL:   ctrl <= ctrl_w;
               `OCL_REG_ACK:    ack_pulse <= w_data[2:0] & {3{w_strb[0]}};
               `OCL_REG_AO_CFG: ao_cfg <= w_data[2:0];
               `OCL_REG_AO_MIN: ao_min <= w_data[15:0];
               `OCL_REG_AO_MAX: ao_max <= w_data[15:0];
               `OCL_REG_HOLD:   hold_cyc <= w_data;
               `OCL_REG_OFFDLY: offdly_cyc <= w_data;
               `OCL_REG_CH_BASE,
               `OCL_REG_CH_BASE + 12'h004,
               `OCL_REG_CH_BASE + 12'h008,
               `OCL_REG_CH_BASE + 12'h00C: ch_cfg[aw_addr[3:2]] <= w_data[18:0];
               default:         s_axi_bresp <= 2'h2;
            endcase
         end
      end
   end

   // ==========================================
   // AXI read channel
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
               `OCL_REG_CTRL:    s_axi_rdata <= ctrl;
               `OCL_REG_ACK:     s_axi_rdata <= 32'h0000_0000;
               `OCL_REG_STATUS:  s_axi_rdata <= {19'h00000, system_contact_o, collective, latched, drive};
               `OCL_REG_AO_CFG:  s_axi_rdata <= {29'h0000_0000, ao_cfg};
               `OCL_REG_AO_MIN:  s_axi_rdata <= {{16{ao_min[15]}}, ao_min};
               `OCL_REG_AO_MAX:  s_axi_rdata <= {{16{ao_max[15]}}, ao_max};
               `OCL_REG_AO_VAL:  s_axi_rdata <= {{16{ao_value_i[15]}}, ao_value_i};
               `OCL_REG_AO_CODE: s_axi_rdata <= {16'h0000, ao_code_o};
               `OCL_REG_HOLD:    s_axi_rdata <= hold_cyc;
               `OCL_REG_OFFDLY:  s_axi_rdata <= offdly_cyc;
               `OCL_REG_CH_BASE,
               `OCL_REG_CH_BASE + 12'h004,
               `OCL_REG_CH_BASE + 12'h008,
               `OCL_REG_CH_BASE + 12'h00C: s_axi_rdata <= {13'h0000, ch_cfg[s_axi_araddr[3:2]]};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Acknowledge sources
   wire remote_en  = ctrl[`OCL_CTRL_REMOTE_EN];
   wire global_ack = remote_en & (global_output_ack_i | ack_pulse[`OCL_ACK_GLOBAL] |
                                  ack_pulse[`OCL_ACK_REMOTE]);
   wire panel_ack  = panel_clear_i | ack_pulse[`OCL_ACK_PANEL];

   // ==========================================
   // Per-channel contact logic
   genvar g;
   generate
      for (g = 0; g < `OCL_NCH; g = g + 1) begin : gen_ch
         wire [6:0]  asgn    = ch_cfg[g][`OCL_CH_ASGN_LSB +: 7];
         wire [6:0]  inv     = ch_cfg[g][`OCL_CH_INV_LSB +: 7];
         wire [6:0]  trig    = trig_i[g*7 +: 7];
         wire [6:0]  slot    = asgn & (trig ^ inv);
         wire        any_as  = |asgn;
         wire        raw_or  = |slot;
         wire        coll    = any_as & (raw_or ^ ch_cfg[g][`OCL_CH_CHINV]);
         wire        lat_en  = ch_cfg[g][`OCL_CH_LATCH];
         wire        ack_any = ch_ack_i[g] | global_ack | panel_ack;
         reg  [31:0] off_cnt;
         reg  [31:0] hold_cnt;
         wire        dropped = ~raw_or & (off_cnt >= offdly_cyc);
         wire        want    = lat_en ? (latched[g] | coll) : coll;
         wire        target  = want ^ ch_cfg[g][`OCL_CH_MODE];

         always @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               off_cnt    <= 32'h0000_0000;
               hold_cnt   <= 32'h0000_0000;
               latched[g] <= 1'b0;
               drive[g]   <= 1'b0;
               collective[g] <= 1'b0;
               relay_o[g] <= 1'b0;
            end else begin
               collective[g] <= coll;
               if (raw_or) begin
                  off_cnt <= 32'h0000_0000;
               end else if (off_cnt != 32'hFFFF_FFFF) begin
                  off_cnt <= off_cnt + 32'h0000_0001;
               end
               if (restore_valid_i) begin
                  latched[g] <= latch_restore_i[g];
               end else if (!lat_en || !any_as) begin
                  latched[g] <= 1'b0;
               end else if (coll) begin
                  latched[g] <= 1'b1;
               end else if (ack_any && dropped) begin
                  latched[g] <= 1'b0;
               end
               if (hold_cnt != 32'h0000_0000) begin
                  hold_cnt <= hold_cnt - 32'h0000_0001;
               end else if (target != drive[g]) begin
                  drive[g]   <= target;
                  relay_o[g] <= target;
                  hold_cnt   <= hold_cyc;
               end
            end
         end
      end
   endgenerate

   // ==========================================
   // System contact: dropped while booting, picks up when fault-free and CTRL bit OCL_CTRL_SYS_OK is set
   reg [15:0] boot_cnt;
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_cnt         <= 16'h0000;
         system_contact_o <= 1'b0;
      end else begin
         if (boot_cnt != `OCL_BOOT_CYC) begin
            boot_cnt <= boot_cnt + 16'h0001;
         end
         system_contact_o <= (boot_cnt == `OCL_BOOT_CYC) & ~fault_i & ctrl[`OCL_CTRL_SYS_OK];
      end
   end

   // ==========================================
   // Analog scaler, values in Q2.14 (16'h4000 = 1.0)
   function signed [17:0] pf_lin;
      input signed [15:0] v;
      begin
         if (v[15]) begin
            pf_lin = -18'sd16384 - {{2{v[15]}}, v};
         end else begin
            pf_lin = 18'sd16384 - {{2{v[15]}}, v};
         end
      end
   endfunction

   wire               is_pf   = ao_cfg[`OCL_AO_PF];
   wire signed [15:0] pf_val  = (ao_p_neg_i ^ ao_q_neg_i) ? -((ao_value_i < 0) ? -ao_value_i : ao_value_i)
                                                         : ((ao_value_i < 0) ? -ao_value_i : ao_value_i);
   wire signed [17:0] x_in    = is_pf ? pf_lin(pf_val) : {{2{ao_value_i[15]}}, ao_value_i};
   wire signed [17:0] x_min   = is_pf ? pf_lin(ao_min) : {{2{ao_min[15]}}, ao_min};
   wire signed [17:0] x_max   = is_pf ? pf_lin(ao_max) : {{2{ao_max[15]}}, ao_max};
   wire signed [18:0] num     = {x_in[17], x_in} - {x_min[17], x_min};
   wire signed [18:0] den     = {x_max[17], x_max} - {x_min[17], x_min};
   wire signed [35:0] prod    = num * $signed({1'b0, 17'h0FFFF});
   wire signed [35:0] ratio   = (den == 19'sd0) ? 36'sd0 : prod / den;
   wire [16:0]        pct     = ratio[35] ? 17'h00000 :
                                (ratio > 36'sd65535) ? `OCL_CODE_FULL : ratio[16:0];
   wire [16:0]        lo      = (ao_cfg[1:0] == `OCL_RANGE_4_20MA) ? `OCL_CODE_4MA : 17'h00000;
   // One count added so that full scale lands on the top code exactly
   wire [16:0]        pct_p1  = pct + 17'h00001;
   wire [33:0]        span    = pct_p1 * (`OCL_CODE_FULL - lo);
   wire [16:0]        code    = lo + span[32:16];

   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ao_code_o <= 16'h0000;
      end else begin
         ao_code_o <= code[15:0];
      end
   end

endmodule // ocl_output_contact_logic
`default_nettype wire

// ===== ocl_map.vh
// Register map, field positions, reset values and timing counts for the output contact logic
// Behaviour
// - Channel ORs up to seven trigger inputs
// - Per-slot inversion complements that trigger
// - Unassigned slot contributes zero, inversion ignored
// - Channel inversion complements collective state
// - No assignments forces zero, inversion ignored
// - Operating mode sets energised contact polarity
// - Unlatched drive follows collective state
// - Latched drive holds until valid acknowledgment
// - Latch clears only after triggers drop
// - Acknowledge waits for off-delay after drop
// - Per-channel acknowledge input resets latch
// - Latched state survives restarts
// - Global acknowledge clears all channel latches
// - Global and remote acknowledge need enable
// - Panel clear key acknowledges latches
// - Minimum hold time after drive change
// - System contact energises after fault-free start with CTRL bit OCL_CTRL_SYS_OK set
// - Analog range 0-20mA, 4-20mA, 0-10V
// - Linear map from minimum to maximum
// - Power factor sign from power signs
// - Power factor transformed by one minus value
`ifndef OCL_MAP_VH
`define OCL_MAP_VH

`define OCL_NCH            4
`define OCL_NSLOT          7

// ==========================================
// Register byte offsets
`define OCL_REG_CTRL       12'h000
`define OCL_REG_ACK        12'h004
`define OCL_REG_STATUS     12'h008
`define OCL_REG_AO_CFG     12'h00C
`define OCL_REG_AO_MIN     12'h010
`define OCL_REG_AO_MAX     12'h014
`define OCL_REG_AO_VAL     12'h018
`define OCL_REG_AO_CODE    12'h01C
`define OCL_REG_HOLD       12'h020
`define OCL_REG_OFFDLY     12'h024
`define OCL_REG_CH_BASE    12'h040
`define OCL_REG_LATCH_BASE 12'h080

// ==========================================
// CTRL fields
`define OCL_CTRL_REMOTE_EN 0
`define OCL_CTRL_SYS_OK    1
// ACK fields (write one pulses)
`define OCL_ACK_GLOBAL     0
`define OCL_ACK_REMOTE     1
`define OCL_ACK_PANEL      2
// Per-channel config fields: [6:0] assign, [14:8] invert, 16 ch invert, 17 mode, 18 latch
`define OCL_CH_ASGN_LSB    0
`define OCL_CH_INV_LSB     8
`define OCL_CH_CHINV       16
`define OCL_CH_MODE        17
`define OCL_CH_LATCH       18
// Analog config fields
`define OCL_AO_RANGE_LSB   0
`define OCL_AO_PF          2
`define OCL_RANGE_0_20MA   2'h0
`define OCL_RANGE_4_20MA   2'h1
`define OCL_RANGE_0_10V    2'h2

// ==========================================
// Output code scale: 16-bit code, full scale of selected range
`define OCL_CODE_FULL      17'h0FFFF
`define OCL_CODE_4MA       17'h03333
`define OCL_PF_ONE         16'h4000

// ==========================================
// Timing, 250 MHz clock
`define OCL_CLK_MHZ        250
`define OCL_BOOT_NS        1000
`define OCL_BOOT_CYC       ((`OCL_BOOT_NS * `OCL_CLK_MHZ + 999) / 1000)
`define OCL_HOLD_RST       32'h0000_0000
`define OCL_OFFDLY_RST     32'h0000_0000

`endif

// ===== ocl_props.sv
// Concurrent checks on the output contact logic ports
`timescale 1ns/1ns
`default_nettype none
module ocl_props (
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic        fault_i,
   input wire logic        system_contact_o,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ==========================================
   // Helper logic: cycles since reset, last write address was the unmapped 12'hFFC
   int unsigned boot_cnt;
   logic        aw_bad;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_cnt <= 0;
         aw_bad <= 1'b0;
      end else begin
         if (boot_cnt < 1000)
            boot_cnt <= boot_cnt + 1;
         if (s_axi_awvalid && s_axi_awready)
            aw_bad <= (s_axi_awaddr == 12'hFFC);
      end
   end
   // ==========================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_sc_fault; fault_i |=> !system_contact_o; endproperty
   a_sc_fault: assert property (p_sc_fault) else $error("system contact on during fault");
   property p_sc_boot; system_contact_o |-> boot_cnt >= 249; endproperty
   a_sc_boot: assert property (p_sc_boot) else $error("system contact on before boot");
   property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_stand: assert property (p_b_stand) else $error("write response dropped early");
   property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_stand: assert property (p_r_stand) else $error("read response dropped early");
   property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rd_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hFFC |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not refused");
   property p_wr_answer; s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_wr_resp; s_axi_bvalid |-> s_axi_bresp == (aw_bad ? 2'h2 : 2'h0); endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response code wrong");
endmodule // ocl_props
bind ocl_output_contact_logic ocl_props u_ocl_props (.mclk_i, .resetn_i, .fault_i, .system_contact_o,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== ocl_contact_load.sv
// External loops wired to the potential-free contacts
`timescale 1ns/1ns
`default_nettype none
module ocl_contact_load (
   input  wire logic [3:0] relay_i,
   input  wire logic       system_contact_i,
   output logic      [4:0] loop_closed_o
);
   // Closing contacts: loop current flows while the contact is picked up
   assign loop_closed_o = {system_contact_i, relay_i};
endmodule // ocl_contact_load
`default_nettype wire

// ===== output_contact_logic_bench.sv
// Self-checking bench for the output contact logic
`timescale 1ns/1ns
`default_nettype none
`include "ocl_map.vh"
module output_contact_logic_bench;
   logic        mclk_i = 1'b0, resetn_i = 1'b0, global_output_ack_i = 1'b0, panel_clear_i = 1'b0;
   logic        restore_valid_i = 1'b0, fault_i = 1'b0, ao_p_neg_i = 1'b0, ao_q_neg_i = 1'b0;
   logic [27:0] trig_i = 28'h0;
   logic [3:0]  ch_ack_i = 4'h0, latch_restore_i = 4'h0;
   logic [15:0] ao_value_i = 16'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, system_contact_o;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire [3:0]   relay_o;
   wire [15:0]  ao_code_o;
   wire [4:0]   loop_closed;
   integer      errors = 0, checks = 0, seed = 32'he7d8, cyc = 0, k, r;
   logic [27:0] t;
   logic [15:0] lo;
   logic [31:0] exp_q[$], msk_q[$];
   logic [15:0] vals[4] = '{16'h0000, 16'h4000, 16'h6000, 16'hF000};
   ocl_output_contact_logic u_ocl_output_contact_logic (.mclk_i, .resetn_i, .trig_i, .ch_ack_i,
      .global_output_ack_i, .panel_clear_i, .latch_restore_i, .restore_valid_i, .fault_i, .ao_value_i,
      .ao_p_neg_i, .ao_q_neg_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .relay_o, .system_contact_o, .ao_code_o);
   ocl_contact_load u_ocl_contact_load (.relay_i(relay_o), .system_contact_i(system_contact_o),
      .loop_closed_o(loop_closed));
   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      checks++;
      if ((got & m) !== (exp & m)) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got & m, exp & m);
      end
   endtask
   task automatic wt(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge mclk_i);
         if (s_axi_awvalid && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk_i); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge mclk_i);
   endtask
   // Expectation is queued here, compared by the response watcher
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk_i); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // Clock, watchdog, response watcher
   initial begin
      forever #2 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish;
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         chk(s_axi_rdata, exp_q[0], msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      wt(16);
      resetn_i <= 1'b1;
      wt(2);
      rd(`OCL_REG_HOLD, `OCL_HOLD_RST, 32'hFFFFFFFF);
      rd(`OCL_REG_AO_MAX, 32'h7FFF, 32'hFFFF);
      rd(`OCL_REG_STATUS, 32'h0, 32'h1000);
      rd(12'hFFC, 32'h0, 32'hFFFFFFFF);
      wr(12'hFFC, 32'h55);
      $display("test reset_values done");
      wr(`OCL_REG_CH_BASE, 32'h0000_0605);
      wr(`OCL_REG_CH_BASE + 12'h004, 32'h0001_7F00);
      wr(`OCL_REG_CH_BASE + 12'h008, 32'h0003_0001);
      wr(`OCL_REG_CH_BASE + 12'h00C, 32'h0001_0040);
      for (k = 0; k < 8; k++) begin
         t = $random(seed);
         trig_i <= t;
         wt(4);
         rd(`OCL_REG_STATUS, {28'h0, ~t[27], t[14], 1'b0, t[0] | ~t[2]}, 32'hF);
      end
      trig_i <= 28'h0;
      $display("test combine done");
      wr(`OCL_REG_OFFDLY, 32'h14);
      wr(`OCL_REG_CH_BASE, 32'h0004_0001);
      trig_i[0] <= 1'b1;
      wt(3);
      trig_i[0] <= 1'b0;
      wt(3);
      rd(`OCL_REG_STATUS, 32'h1, 32'h1);
      ch_ack_i[0] <= 1'b1;
      wt(1);
      ch_ack_i[0] <= 1'b0;
      wt(30);
      rd(`OCL_REG_STATUS, 32'h1, 32'h1);
      global_output_ack_i <= 1'b1;
      wt(1);
      global_output_ack_i <= 1'b0;
      wt(4);
      rd(`OCL_REG_STATUS, 32'h1, 32'h1);
      wr(`OCL_REG_CTRL, 32'h3);
      global_output_ack_i <= 1'b1;
      wt(1);
      global_output_ack_i <= 1'b0;
      wt(4);
      rd(`OCL_REG_STATUS, 32'h0, 32'h1);
      for (k = 0; k < 4; k++) begin
         trig_i[0] <= 1'b1;
         wt(3);
         trig_i[0] <= 1'b0;
         wt(30);
         case (k)
            0: panel_clear_i <= 1'b1;
            1: ch_ack_i[0] <= 1'b1;
            2: wr(`OCL_REG_ACK, 32'h1);
            default: wr(`OCL_REG_ACK, 32'h2);
         endcase
         wt(1);
         panel_clear_i <= 1'b0;
         ch_ack_i <= 4'h0;
         wt(4);
         rd(`OCL_REG_STATUS, 32'h0, 32'h1);
      end
      trig_i[0] <= 1'b1;
      wt(30);
      ch_ack_i[0] <= 1'b1;
      wt(1);
      ch_ack_i[0] <= 1'b0;
      wt(4);
      rd(`OCL_REG_STATUS, 32'h1, 32'h1);
      trig_i[0] <= 1'b0;
      wt(30);
      wr(`OCL_REG_CH_BASE, 32'h0000_0001);
      wt(3);
      rd(`OCL_REG_STATUS, 32'h0, 32'h1);
      wr(`OCL_REG_CH_BASE, 32'h0004_0001);
      latch_restore_i <= 4'h1;
      restore_valid_i <= 1'b1;
      wt(1);
      restore_valid_i <= 1'b0;
      wt(3);
      rd(`OCL_REG_STATUS, 32'h1, 32'h1);
      wr(`OCL_REG_CH_BASE, 32'h0004_0000);
      wt(3);
      rd(`OCL_REG_STATUS, 32'h0, 32'h1);
      $display("test latching done");
      wr(`OCL_REG_HOLD, 32'h14);
      wr(`OCL_REG_CH_BASE, 32'h0000_0001);
      trig_i[0] <= 1'b1;
      wt(3);
      trig_i[0] <= 1'b0;
      wt(2);
      rd(`OCL_REG_STATUS, 32'h1, 32'h1);
      chk({27'h0, loop_closed}, 32'h1, 32'h1);
      wt(30);
      rd(`OCL_REG_STATUS, 32'h0, 32'h1);
      chk({27'h0, loop_closed}, 32'h0, 32'h1);
      $display("test hold done");
      rd(`OCL_REG_STATUS, 32'h1000, 32'h1000);
      chk({27'h0, loop_closed}, 32'h10, 32'h10);
      fault_i <= 1'b1;
      wt(3);
      rd(`OCL_REG_STATUS, 32'h0, 32'h1000);
      fault_i <= 1'b0;
      $display("test system_contact done");
      wr(`OCL_REG_AO_MIN, 32'h0);
      wr(`OCL_REG_AO_MAX, 32'h4000);
      for (r = 0; r < 3; r++) begin
         wr(`OCL_REG_AO_CFG, r);
         lo = (r == 1) ? 16'(`OCL_CODE_4MA) : 16'h0;
         for (k = 0; k < 4; k++) begin
            ao_value_i <= vals[k];
            wt(4);
            rd(`OCL_REG_AO_CODE, (k == 1 || k == 2) ? 32'hFFFF : {16'h0, lo}, 32'hFFFF);
         end
      end
      // Power factor: range -0.5 to +0.5, sign from the two power signs
      wr(`OCL_REG_AO_CFG, 32'h4);
      wr(`OCL_REG_AO_MIN, 32'hE000);
      wr(`OCL_REG_AO_MAX, 32'h2000);
      for (k = 0; k < 5; k++) begin
         ao_value_i <= (k == 4) ? 16'h4000 : 16'h2000;
         ao_p_neg_i <= k[0];
         ao_q_neg_i <= k[1];
         wt(4);
         rd(`OCL_REG_AO_CODE, (k == 4) ? 32'h7FFF : (k[0] ^ k[1]) ? 32'h0 : 32'hFFFF, 32'hFFFF);
      end
      $display("test analog done");
      wt(4);
      tally_and_finish;
   end
endmodule // output_contact_logic_bench
`default_nettype wire
